/* File: rtl/eecl_loader.sv */
// Purpose: Power-up configuration loader and host write follower over a serial EEPROM
// Assumes: 40 MHz core clock; host drives the lines only after the load window
// Notes: Configuration words leave as one flat vector, word 0 in the low bits
`include "eecl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module eecl_loader #(
  parameter int NUM_REGS = 40,
  parameter int SK_HALF_CYCLES = `EECL_SK_HALF_CYCLES,
  parameter int LOAD_WINDOW_CYCLES =
    `EECL_LOAD_WINDOW_MS * (`EECL_NS_PER_MS / `EECL_CLOCK_PERIOD_NS),
  parameter logic [`EECL_DATA_W-1:0] SIGNATURE = `EECL_SIGNATURE,
  parameter logic [NUM_REGS*`EECL_DATA_W-1:0] CONFIG_DEFAULT = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic active_low_reset_in,
  input wire logic eeprom_select_i,
  output logic eeprom_select_o,
  output logic eeprom_select_oe,
  input wire logic eeprom_shift_clock_i,
  output logic eeprom_shift_clock_o,
  output logic eeprom_shift_clock_oe,
  input wire logic eeprom_serial_in_i,
  output logic eeprom_serial_in_o,
  output logic eeprom_serial_in_oe,
  input wire logic eeprom_serial_out_i,
  output logic eeprom_serial_out_o,
  output logic eeprom_serial_out_oe,
  output logic [NUM_REGS*`EECL_DATA_W-1:0] config_q,
  output logic signature_ok_q,
  output logic load_done_q,
  output logic monitor_active
);
  import eecl_pkg::*;

  localparam int DW = `EECL_DATA_W;
  localparam int LOAD_CYCLES = NUM_REGS * (`EECL_READ_BITS + 2) * 2 * SK_HALF_CYCLES;

  initial begin
    if (NUM_REGS < 2 || NUM_REGS > 64 || SK_HALF_CYCLES < 1
        || LOAD_WINDOW_CYCLES <= LOAD_CYCLES || LOAD_WINDOW_CYCLES >= 2**24) begin
      $error("eecl_loader: unsupported parameter values");
    end
  end

  eecl_phase_t phase_q;
  eecl_load_state_t load_state_q;
  logic [2:0] rstn_sync_q;
  logic [1:0] do_sync_q;
  logic [1:0] cs_sync_q;
  logic [2:0] tog_sync_q;
  logic [23:0] window_q;
  logic [15:0] div_q;
  logic sk_tick;
  logic sk_q;
  logic cs_q;
  logic di_q;
  logic [4:0] bit_q;
  logic [`EECL_ADDR_W-1:0] word_q;
  logic [DW-1:0] read_q;
  logic [`EECL_CMD_BITS-1:0] cmd;
  logic pending_q;
  logic [`EECL_ADDR_W-1:0] snoop_addr;
  logic [DW-1:0] snoop_data;
  logic snoop_toggle;

  // Pin reset and EEPROM data out pass two flops before use
  always_ff @(posedge clock) begin
    if (srst) begin
      rstn_sync_q <= 3'h0;
      do_sync_q <= 2'h0;
      cs_sync_q <= 2'h0;
      tog_sync_q <= 3'h0;
    end else begin
      rstn_sync_q <= {rstn_sync_q[1:0], active_low_reset_in};
      do_sync_q <= {do_sync_q[0], eeprom_serial_out_i};
      cs_sync_q <= {cs_sync_q[0], eeprom_select_i};
      tog_sync_q <= {tog_sync_q[1:0], snoop_toggle};
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !rstn_sync_q[1]) begin
      phase_q <= PH_RESET;
      window_q <= 24'h000000;
    end else begin
      case (phase_q)
        PH_RESET: begin
          if (!rstn_sync_q[2]) begin
            phase_q <= PH_LOAD;
          end
        end
        PH_LOAD: begin
          window_q <= window_q + 24'h000001;
          if (window_q == 24'(LOAD_WINDOW_CYCLES - 1)) begin
            phase_q <= PH_MONITOR;
          end
        end
        PH_MONITOR: phase_q <= PH_MONITOR;
        default: phase_q <= PH_RESET;
      endcase
    end
  end

  assign monitor_active = (phase_q == PH_MONITOR);

  // drive only during the load window
  assign eeprom_select_oe = (phase_q == PH_LOAD);
  assign eeprom_shift_clock_oe = (phase_q == PH_LOAD);
  assign eeprom_serial_in_oe = (phase_q == PH_LOAD);
  assign eeprom_serial_out_oe = 1'b0;
  assign eeprom_serial_out_o = 1'b0;
  assign eeprom_select_o = cs_q;
  assign eeprom_shift_clock_o = sk_q;
  assign eeprom_serial_in_o = di_q;

  assign sk_tick = (div_q == 16'(SK_HALF_CYCLES - 1));
  assign cmd = {1'b1, `EECL_OP_READ, word_q};

  always_ff @(posedge clock) begin
    if (srst || phase_q != PH_LOAD || sk_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // master read of each word as its own READ frame
  always_ff @(posedge clock) begin
    if (srst || phase_q != PH_LOAD) begin
      load_state_q <= LD_IDLE;
      sk_q <= 1'b0;
      cs_q <= 1'b0;
      di_q <= 1'b0;
      bit_q <= 5'h00;
      word_q <= `EECL_SIG_ADDR;
      read_q <= '0;
      signature_ok_q <= (phase_q == PH_MONITOR) ? signature_ok_q : 1'b0;
      load_done_q <= (phase_q == PH_MONITOR) ? load_done_q : 1'b0;
    end else if (sk_tick) begin
      case (load_state_q)
        LD_IDLE: load_state_q <= LD_SELECT;
        LD_SELECT: begin
          cs_q <= 1'b1;
          di_q <= cmd[`EECL_CMD_BITS-1];
          bit_q <= 5'h00;
          load_state_q <= LD_SHIFT;
        end
        LD_SHIFT: begin
          sk_q <= ~sk_q;
          if (!sk_q) begin
            bit_q <= bit_q + 5'h01;
            read_q <= {read_q[DW-2:0], do_sync_q[1]};
          end else if (bit_q == 5'(`EECL_READ_BITS)) begin
            load_state_q <= LD_DESELECT;
          end else if (bit_q < 5'(`EECL_CMD_BITS)) begin
            di_q <= cmd[4'(`EECL_CMD_BITS - 1) - bit_q[3:0]];
          end else begin
            di_q <= 1'b0;
          end
        end
        LD_DESELECT: begin
          cs_q <= 1'b0;
          di_q <= 1'b0;
          word_q <= word_q + 6'h01;
          if (word_q == `EECL_SIG_ADDR && read_q != SIGNATURE) begin
            load_state_q <= LD_DONE;
          end else if (word_q == 6'(NUM_REGS - 1)) begin
            load_state_q <= LD_DONE;
          end else begin
            load_state_q <= LD_SELECT;
          end
          if (word_q == `EECL_SIG_ADDR) begin
            signature_ok_q <= (read_q == SIGNATURE);
          end
        end
        LD_DONE: load_done_q <= 1'b1;
        default: load_state_q <= LD_IDLE;
      endcase
    end
  end

  eecl_snoop u_snoop (
    .snoop_clock(eeprom_shift_clock_i),
    .srst(srst),
    .select_in(eeprom_select_i),
    .serial_in(eeprom_serial_in_i),
    .write_addr_q(snoop_addr),
    .write_data_q(snoop_data),
    .write_toggle_q(snoop_toggle)
  );

  // pending write, independent of any fitted EEPROM
  always_ff @(posedge clock) begin
    if (srst || phase_q != PH_MONITOR) begin
      pending_q <= 1'b0;
    end else if (tog_sync_q[2] != tog_sync_q[1]) begin
      pending_q <= 1'b1;
    end else if (!cs_sync_q[1]) begin
      pending_q <= 1'b0;
    end
  end

  // Configuration words: defaults, loaded words, host writes
  always_ff @(posedge clock) begin
    if (srst || phase_q == PH_RESET) begin
      config_q <= CONFIG_DEFAULT;
    end else if (phase_q == PH_LOAD) begin
      if (sk_tick && load_state_q == LD_DESELECT && word_q != `EECL_SIG_ADDR
          && signature_ok_q) begin
        config_q[word_q*DW +: DW] <= read_q;
      end
    end else if (pending_q && !cs_sync_q[1] && tog_sync_q[2] == tog_sync_q[1]
                 && {1'b0, snoop_addr} < 7'(NUM_REGS)) begin
      config_q[snoop_addr*DW +: DW] <= snoop_data;
    end
  end

endmodule // eecl_loader

`default_nettype wire

/* File: rtl/eecl_pkg.sv */
// Purpose: Types of the serial EEPROM configuration loader
// Assumes: Nothing beyond the constants header
// Notes: Holds enumerations only
package eecl_pkg;

  typedef enum logic [1:0] {
    PH_RESET,
    PH_LOAD,
    PH_MONITOR
  } eecl_phase_t;

  typedef enum logic [2:0] {
    LD_IDLE,
    LD_SELECT,
    LD_SHIFT,
    LD_DESELECT,
    LD_DONE
  } eecl_load_state_t;

endpackage

/* File: rtl/eecl_regs.svh */
// Purpose: Shared constants of the serial EEPROM configuration loader
// Assumes: 16-bit words, 6-bit word address, serial framing of a 64-word part
// Notes: Definitions only
`ifndef EECL_REGS_SVH
`define EECL_REGS_SVH

`define EECL_DATA_W 16
`define EECL_ADDR_W 6
`define EECL_OP_W 2
`define EECL_OP_READ 2'h2
`define EECL_OP_WRITE 2'h1
`define EECL_SIG_ADDR 6'h00
`define EECL_CMD_BITS 9
`define EECL_READ_BITS 26
`define EECL_FRAME_BITS 24
`define EECL_LOAD_WINDOW_MS 30
`define EECL_CLOCK_PERIOD_NS 25
`define EECL_NS_PER_MS 1000000
`define EECL_SIGNATURE 16'hA55A
`define EECL_SK_HALF_CYCLES 4

`endif

/* File: rtl/eecl_snoop.sv */
// Purpose: Watches host frames on the shared EEPROM lines, link clock domain
// Assumes: Shift clock comes from the host; data sampled on its rising edge
// Notes: Select low clears the frame, so a stopped clock needs no edge
`include "eecl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module eecl_snoop (
  input wire logic snoop_clock,
  input wire logic srst,
  input wire logic select_in,
  input wire logic serial_in,
  output logic [`EECL_ADDR_W-1:0] write_addr_q,
  output logic [`EECL_DATA_W-1:0] write_data_q,
  output logic write_toggle_q
);
  import eecl_pkg::*;

  logic [4:0] bit_count_q;
  logic [`EECL_FRAME_BITS-2:0] shift_q;
  logic [`EECL_FRAME_BITS-1:0] frame;

  assign frame = {shift_q, serial_in};

  // Frame ends with its own select; leading zeros before the start bit are skipped
  always_ff @(posedge snoop_clock or negedge select_in) begin
    if (!select_in) begin
      bit_count_q <= 5'h00;
      shift_q <= '0;
    end else if (bit_count_q == 5'h00) begin
      if (serial_in) begin
        bit_count_q <= 5'h01;
      end
    end else if (bit_count_q <= 5'(`EECL_FRAME_BITS)) begin
      bit_count_q <= bit_count_q + 5'h01;
      shift_q <= frame[`EECL_FRAME_BITS-2:0];
    end
  end

  always_ff @(posedge snoop_clock or posedge srst) begin
    if (srst) begin
      write_addr_q <= '0;
      write_data_q <= '0;
      write_toggle_q <= 1'b0;
    end else if (select_in && bit_count_q == 5'(`EECL_FRAME_BITS)
                 && frame[`EECL_FRAME_BITS-1 -: `EECL_OP_W] == `EECL_OP_WRITE) begin
      write_addr_q <= frame[`EECL_DATA_W +: `EECL_ADDR_W];
      write_data_q <= frame[`EECL_DATA_W-1:0];
      write_toggle_q <= ~write_toggle_q;
    end
  end

endmodule // eecl_snoop

`default_nettype wire

/* File: testbench/eecl_eeprom_model.sv */
// Purpose: Serial EEPROM answering read frames
// Assumes: Output changes after falling shift clock
// Notes: Released output shows inverse of last bit
`timescale 1ns/1ps
`default_nettype none
module eecl_eeprom_model (
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic dout
);
  logic [15:0] mem [64];
  logic [8:0] sr_q;
  logic [5:0] a_q;
  int n_q = 0;
  initial dout = 1'h1;
  always @(posedge sk) begin
    if (cs) begin
      sr_q <= {sr_q[7:0], di};
      n_q <= n_q + 1;
    end
  end
  always @(negedge sk) begin
    if (cs && n_q == 9) begin
      a_q <= sr_q[5:0];
      dout <= 1'h0;
    end else if (cs && n_q > 9 && n_q < 26) begin
      dout <= mem[a_q][25-n_q];
    end
  end
  always @(negedge cs) begin
    n_q <= 0;
    dout <= ~dout;
  end
endmodule // eecl_eeprom_model
`default_nettype wire

/* File: testbench/eecl_loader_assertions.sv */
// Purpose: Port checks of the loader
// Assumes: Core clock domain only
// Notes: Bind follows the module
`include "eecl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module eecl_loader_chk #(
  parameter int NUM_REGS = 40,
  parameter int LOAD_WINDOW_CYCLES = 1200000,
  parameter logic [NUM_REGS*`EECL_DATA_W-1:0] CONFIG_DEFAULT = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic active_low_reset_in,
  input wire logic eeprom_select_i,
  input wire logic eeprom_select_o,
  input wire logic eeprom_select_oe,
  input wire logic eeprom_shift_clock_oe,
  input wire logic eeprom_serial_in_oe,
  input wire logic eeprom_serial_out_oe,
  input wire logic [NUM_REGS*`EECL_DATA_W-1:0] config_q,
  input wire logic signature_ok_q,
  input wire logic load_done_q,
  input wire logic monitor_active
);
  int win_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  always_ff @(posedge clock) begin
    if (srst || !eeprom_select_oe) begin
      win_q <= 0;
    end else begin
      win_q <= win_q + 1;
    end
  end
  sequence cs_gap_s;
    !eeprom_select_o [*3];
  endsequence
  AST_FLOAT:
  assert property (!active_low_reset_in [*6] |-> !eeprom_select_oe) else $error("driven");
  AST_DRIVE:
  assert property ($rose(active_low_reset_in) |-> ##[1:5] eeprom_select_oe) else $error("idle");
  AST_TIED:
  assert property (eeprom_select_oe == eeprom_shift_clock_oe && !eeprom_serial_out_oe
    && eeprom_select_oe == eeprom_serial_in_oe) else $error("enables");
  AST_WINDOW:
  assert property ($fell(eeprom_select_oe) && active_low_reset_in |-> monitor_active &&
    win_q inside {[LOAD_WINDOW_CYCLES-1:LOAD_WINDOW_CYCLES+1]}) else $error("window");
  AST_EXCL:
  assert property (!(monitor_active && eeprom_select_oe)) else $error("overlap");
  AST_BAD_SIG:
  assert property (load_done_q && !signature_ok_q && !monitor_active |->
    config_q == CONFIG_DEFAULT) else $error("default");
  AST_GAP:
  assert property ($fell(eeprom_select_o) && eeprom_select_oe |-> cs_gap_s) else $error("gap");
  AST_COMMIT:
  assert property (monitor_active && eeprom_select_i && $past(eeprom_select_i, 6) |->
    $stable(config_q)) else $error("early");
endmodule // eecl_loader_chk
bind eecl_loader eecl_loader_chk #(.NUM_REGS(NUM_REGS), .LOAD_WINDOW_CYCLES(LOAD_WINDOW_CYCLES),
  .CONFIG_DEFAULT(CONFIG_DEFAULT)) i_eecl_loader_chk (.clock, .srst, .active_low_reset_in,
  .eeprom_select_i, .eeprom_select_o, .eeprom_select_oe, .eeprom_shift_clock_oe,
  .eeprom_serial_in_oe, .eeprom_serial_out_oe, .config_q, .signature_ok_q, .load_done_q,
  .monitor_active);
`default_nettype wire

/* File: testbench/test_eeprom_config_loader.sv */
// Purpose: Bench of the loader
// Assumes: Short window, eight words
// Notes: Host frames on a 32 ns link clock
`include "eecl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((e) !== (a)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module test_eeprom_config_loader;
  localparam int NR = 8;
  logic clock, srst, active_low_reset_in, hcs, hsk, hdi, eeprom_serial_out_i, sig_e;
  logic eeprom_select_o, eeprom_select_oe, eeprom_shift_clock_o, eeprom_shift_clock_oe;
  logic eeprom_serial_in_o, eeprom_serial_in_oe, eeprom_serial_out_o, eeprom_serial_out_oe;
  logic signature_ok_q, load_done_q, monitor_active;
  logic [NR*16-1:0] config_q, cfg_e;
  logic [NR*16:0] exp_q[$];
  int n_errors = 0, checked = 0, cycles = 0, seed;
  event look;
  wire logic eeprom_select_i = eeprom_select_oe ? eeprom_select_o : hcs;
  wire logic eeprom_shift_clock_i = eeprom_shift_clock_oe ? eeprom_shift_clock_o : hsk;
  wire logic eeprom_serial_in_i = eeprom_serial_in_oe ? eeprom_serial_in_o : hdi;
  eecl_loader #(.NUM_REGS(NR), .LOAD_WINDOW_CYCLES(4000)) i_eecl_loader (.clock, .srst,
    .active_low_reset_in, .eeprom_select_i, .eeprom_select_o, .eeprom_select_oe,
    .eeprom_shift_clock_i, .eeprom_shift_clock_o, .eeprom_shift_clock_oe,
    .eeprom_serial_in_i, .eeprom_serial_in_o, .eeprom_serial_in_oe, .eeprom_serial_out_i,
    .eeprom_serial_out_o, .eeprom_serial_out_oe, .config_q, .signature_ok_q, .load_done_q,
    .monitor_active);
  eecl_eeprom_model i_eecl_eeprom_model (.cs(eeprom_select_i), .sk(eeprom_shift_clock_i),
    .di(eeprom_serial_in_i), .dout(eeprom_serial_out_i));
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic note();
    exp_q.push_back({sig_e, cfg_e});
    -> look;
    @(negedge clock);
  endtask
  always @(look) begin
    logic [NR*16:0] e;
    e = exp_q.pop_front();
    `CHK("config", e, {signature_ok_q, config_q})
    `CHK("done", 1'h1, load_done_q)
  end
  task automatic host_frame(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    logic [24:0] f;
    f = {1'h1, op, a, d};
    hcs = 1'h1;
    #16;
    for (int b = 24; b >= 0; b--) begin
      hdi = f[b];
      #16 hsk = 1'h1;
      #16 hsk = 1'h0;
    end
    #16 hcs = 1'h0;
    hdi = ~hdi;
    if (op == `EECL_OP_WRITE && a < NR) cfg_e[a*16 +: 16] = d;
    repeat (10) @(negedge clock);
    note();
  endtask
  initial begin
    logic [1:0] ops [9];
    logic [5:0] adr [9];
    ops = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
    adr = '{6'h00, 6'h30, 6'h00, 6'h10, 6'h20, 6'h01, 6'h02, 6'h08, 6'h00};
    srst = 1'h1;
    active_low_reset_in = 1'h0;
    hcs = 1'h0;
    hsk = 1'h0;
    hdi = 1'h0;
    seed = 32'hBAC8;
    adr[0] = 6'h01 + (6'($random(seed)) & 6'h03);
    for (int i = 0; i < NR; i++) i_eecl_eeprom_model.mem[i] = 16'($random(seed));
    i_eecl_eeprom_model.mem[0] = `EECL_SIGNATURE;
    cfg_e = '0;
    for (int i = 1; i < NR; i++) cfg_e[i*16 +: 16] = i_eecl_eeprom_model.mem[i];
    sig_e = 1'h1;
    repeat (3) @(negedge clock);
    srst = 1'h0;
    repeat (3) @(negedge clock);
    active_low_reset_in = 1'h1;
    wait (monitor_active === 1'h1);
    @(negedge clock);
    note();
    #7;
    for (int k = 0; k < 9; k++) host_frame(ops[k], adr[k], 16'($random(seed)));
    i_eecl_eeprom_model.mem[0] = ~`EECL_SIGNATURE;
    active_low_reset_in = 1'h0;
    repeat (8) @(negedge clock);
    active_low_reset_in = 1'h1;
    cfg_e = '0;
    sig_e = 1'h0;
    wait (monitor_active === 1'h1);
    @(negedge clock);
    note();
    host_frame(2'h1, 6'h03, 16'($random(seed)));
    give_verdict();
  end
endmodule // test_eeprom_config_loader
`default_nettype wire
